// >>> src/apd_ctrl.sv
// Host-side controller for a 1M x 16 page-mode DRAM with two byte-lane strobes.
// Assumes the memory pins are wired directly; data pins are split in/out/enable.
`timescale 1ns/10ps

module apd_ctrl (
  input wire logic i_clk,                     // 50 MHz clock
  input wire logic i_rst_b,                   // Synchronous reset, low
  input wire logic i_req_valid,               // Access request present
  input apd_pkg::apd_req_t i_req,             // Access request
  output logic o_req_ready,                   // Request taken when valid and ready
  output logic o_rd_valid,                    // Read data pulse
  output logic [15:0] o_rd_data,              // Read data, unstrobed lanes zero
  input wire logic i_self_refresh,            // Hold memory in self-refresh, level
  output logic o_self_active,                 // Memory in self-refresh
  output apd_pkg::apd_pins_t o_pins,          // Memory control and address pins
  input wire logic [15:0] i_dq,               // Data pins, input side
  output logic [15:0] o_dq,                   // Data pins, output side
  output logic [15:0] o_dq_oe                 // Data pin drive enable, high drives
);
  import apd_pkg::*;

  typedef enum logic [11:0] {
    ST_IDLE = 12'h001,
    ST_ROWA = 12'h002,
    ST_RHLD = 12'h004,
    ST_COLA = 12'h008,
    ST_STRB = 12'h010,
    ST_PAGE = 12'h020,
    ST_HUP  = 12'h040,
    ST_HDN  = 12'h080,
    ST_REFC = 12'h100,
    ST_REFR = 12'h200,
    ST_SELF = 12'h400,
    ST_PRE  = 12'h800
  } apd_state_t;

  apd_state_t state_r;
  apd_req_t req_r;
  logic [3:0] tmr_r;
  logic [3:0] rc_r;
  logic [10:0] page_cnt_r;
  logic ref_due;
  logic ref_ack_r;
  logic self_req_r;
  logic take;

  // Lane mask expanded to data bits
  function automatic logic [15:0] lane_bits(input logic [1:0] lanes);
    return {{8{lanes[1]}}, {8{lanes[0]}}};
  endfunction

  assign take = i_req_valid && o_req_ready;

  // ************************************************************
  // Refresh interval
  // ************************************************************
  apd_refresh_timer u_refresh (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_ack(ref_ack_r),
    .o_due(ref_due)
  );

  // Random cycle guard, loaded when the row strobe falls
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      rc_r <= TMR_RST;
    end else if (o_pins.row_strobe_n && (state_r == ST_ROWA || state_r == ST_HUP ||
                 state_r == ST_REFC)) begin
      rc_r <= RC_LD;
    end else if (rc_r != TMR_RST) begin
      rc_r <= rc_r - 4'h1;
    end
  end

  // ************************************************************
  // Sequencer: pins, timers, handshake
  // ************************************************************
  // Outputs are set on entry to each state so every pin comes from a flop
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      state_r <= ST_IDLE;
      req_r <= '0;
      tmr_r <= TMR_RST;
      page_cnt_r <= 11'h000;
      o_pins <= PINS_IDLE;
      o_dq <= 16'h0000;
      o_dq_oe <= 16'h0000;
      o_req_ready <= 1'b0;
      o_rd_valid <= 1'b0;
      o_rd_data <= 16'h0000;
      o_self_active <= 1'b0;
      ref_ack_r <= 1'b0;
      self_req_r <= 1'b0;
    end else begin
      o_rd_valid <= 1'b0;
      ref_ack_r <= 1'b0;
      if (tmr_r != TMR_RST) begin
        tmr_r <= tmr_r - 4'h1;
      end
      case (state_r)
        ST_IDLE: begin
          if (take) begin
            req_r <= i_req;
            o_req_ready <= 1'b0;
            page_cnt_r <= 11'h000;
            o_pins.muxed_address_lines <= i_req.row;
            state_r <= ST_ROWA;
          end else if (ref_due || i_self_refresh) begin
            // Column-first refresh: both lanes low ahead of the row strobe
            o_req_ready <= 1'b0;
            self_req_r <= i_self_refresh;
            o_pins.low_lane_column_strobe_n <= 1'b0;
            o_pins.high_lane_column_strobe_n <= 1'b0;
            state_r <= ST_REFC;
          end else begin
            o_req_ready <= 1'b1;
          end
        end
        ST_ROWA: begin
          o_pins.row_strobe_n <= 1'b0;
          state_r <= ST_RHLD;
        end
        ST_RHLD: begin
          // Row address held one cycle past the fall, then the column goes out
          o_pins.muxed_address_lines <= req_r.col;
          o_pins.write_en_n <= !req_r.write;
          o_pins.out_en_n <= req_r.write;
          o_dq <= req_r.wdata;
          o_dq_oe <= req_r.write ? lane_bits(req_r.lanes) : 16'h0000;
          state_r <= ST_COLA;
        end
        ST_COLA: begin
          // Write enable and data settled a cycle before the strobes fall
          o_pins.low_lane_column_strobe_n <= !req_r.lanes[0];
          o_pins.high_lane_column_strobe_n <= !req_r.lanes[1];
          tmr_r <= STRB_LD;
          state_r <= ST_STRB;
        end
        ST_STRB: begin
          if (tmr_r == TMR_RST) begin
            if (!req_r.write) begin
              o_rd_valid <= 1'b1;
              o_rd_data <= i_dq & lane_bits(req_r.lanes);
            end
            if (req_r.hold_row && page_cnt_r != PAGE_LAST && !ref_due) begin
              // Strobes up, row stays open for the next column
              o_pins.low_lane_column_strobe_n <= 1'b1;
              o_pins.high_lane_column_strobe_n <= 1'b1;
              o_dq_oe <= 16'h0000;
              o_req_ready <= 1'b1;
              state_r <= ST_PAGE;
            end else if (!req_r.write && ref_due) begin
              // Hidden refresh: lane strobes stay low, data stays on the pins
              o_pins.row_strobe_n <= 1'b1;
              state_r <= ST_HUP;
            end else begin
              o_pins <= PINS_IDLE;
              o_dq_oe <= 16'h0000;
              tmr_r <= RP_LD;
              state_r <= ST_PRE;
            end
          end
        end
        ST_PAGE: begin
          // Ready is already up, so a presented request must be taken before closing
          if (take) begin
            // Row field of a page request is ignored; the open row is kept
            req_r <= i_req;
            o_req_ready <= 1'b0;
            page_cnt_r <= page_cnt_r + 11'h001;
            o_pins.muxed_address_lines <= i_req.col;
            o_pins.write_en_n <= !i_req.write;
            o_pins.out_en_n <= i_req.write;
            o_dq <= i_req.wdata;
            o_dq_oe <= i_req.write ? lane_bits(i_req.lanes) : 16'h0000;
            // Four cycles per column keeps well above the page cycle floor
            state_r <= ST_COLA;
          end else if (ref_due || page_cnt_r == PAGE_LAST) begin
            // A due refresh closes the row so it is never held open too long
            o_req_ready <= 1'b0;
            o_pins <= PINS_IDLE;
            tmr_r <= RP_LD;
            state_r <= ST_PRE;
          end
        end
        ST_HUP: begin
          o_pins.row_strobe_n <= 1'b0;
          ref_ack_r <= 1'b1;
          tmr_r <= RAS_LD;
          state_r <= ST_HDN;
        end
        ST_HDN: begin
          if (tmr_r == TMR_RST) begin
            o_pins <= PINS_IDLE;
            tmr_r <= RP_LD;
            state_r <= ST_PRE;
          end
        end
        ST_REFC: begin
          o_pins.row_strobe_n <= 1'b0;
          ref_ack_r <= 1'b1;
          tmr_r <= RAS_LD;
          state_r <= ST_REFR;
        end
        ST_REFR: begin
          if (tmr_r == TMR_RST) begin
            if (self_req_r && i_self_refresh) begin
              o_self_active <= 1'b1;
              state_r <= ST_SELF;
            end else begin
              o_pins <= PINS_IDLE;
              tmr_r <= RP_LD;
              state_r <= ST_PRE;
            end
          end
        end
        ST_SELF: begin
          // Memory refreshes itself while the row strobe stays low
          if (!i_self_refresh) begin
            o_self_active <= 1'b0;
            self_req_r <= 1'b0;
            o_pins <= PINS_IDLE;
            tmr_r <= RP_LD;
            state_r <= ST_PRE;
          end
        end
        ST_PRE: begin
          if (tmr_r == TMR_RST && rc_r == TMR_RST) begin
            // A due refresh keeps ready low so a request stream cannot starve it
            o_req_ready <= !ref_due;
            state_r <= ST_IDLE;
          end
        end
        default: begin
          o_pins <= PINS_IDLE;
          o_dq_oe <= 16'h0000;
          o_req_ready <= 1'b0;
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // apd_ctrl

// >>> shared/apd_pkg.sv
// Shared constants and carrier types for the page-mode DRAM strobe controller.
// Assumes one 50 MHz clock; all times are converted to whole cycles here.
package apd_pkg;

  // ************************************************************
  // Clock and timing
  // ************************************************************
  localparam int CLK_NS = 20;                 // 50 MHz period
  localparam int T_PC_NS = 25;                // Least page-mode column cycle (slower grade)
  localparam int T_RC_NS = 104;               // Least random cycle (slower grade)
  localparam int T_CAC_NS = 15;               // Column strobe to data, slower grade
  localparam int T_RP_NS = 40;                // Row precharge, chosen
  localparam int T_RAS_NS = 60;               // Row strobe low for refresh, chosen
  localparam int REF_ROWS = 1024;             // Rows covered per interval
  localparam int REF_INTERVAL_MS = 16;        // Normal refresh interval
  localparam int PAGE_MAX = 1024;             // Columns per open row

  function automatic int ceil_cyc(input int ns);
    return (ns + CLK_NS - 1) / CLK_NS;
  endfunction

  localparam int T_PC_CYC = ceil_cyc(T_PC_NS);
  localparam int T_RC_CYC = ceil_cyc(T_RC_NS);
  // One extra cycle so data is settled when sampled at the end of the strobe
  localparam int T_STRB_CYC = ceil_cyc(T_CAC_NS) + 1;
  localparam int T_RP_CYC = ceil_cyc(T_RP_NS);
  localparam int T_RAS_CYC = ceil_cyc(T_RAS_NS);
  // Longest spacing between refreshes rounds down
  localparam int REFI_CYC = (REF_INTERVAL_MS * 1000000 / REF_ROWS) / CLK_NS;

  localparam logic [3:0] TMR_RST = 4'h0;
  localparam logic [3:0] STRB_LD = 4'(T_STRB_CYC - 1);
  localparam logic [3:0] RP_LD = 4'(T_RP_CYC - 1);
  localparam logic [3:0] RAS_LD = 4'(T_RAS_CYC - 1);
  localparam logic [3:0] RC_LD = 4'(T_RC_CYC - 1);
  localparam logic [10:0] PAGE_LAST = 11'(PAGE_MAX - 1);
  localparam logic [9:0] REFI_LAST = 10'(REFI_CYC - 1);

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic write;                              // 1 = write, 0 = read
    logic [1:0] lanes;                        // Bit 1 high byte, bit 0 low byte
    logic [9:0] row;
    logic [9:0] col;
    logic [15:0] wdata;
    logic hold_row;                           // Leave row open for a page access
  } apd_req_t;

  typedef struct packed {
    logic row_strobe_n;
    logic high_lane_column_strobe_n;
    logic low_lane_column_strobe_n;
    logic write_en_n;
    logic out_en_n;
    logic [9:0] muxed_address_lines;
  } apd_pins_t;

  localparam apd_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 10'h000};

endpackage

// >>> src/apd_refresh_timer.sv
// Refresh interval timer: raises a sticky due flag once per refresh slot.
// Assumes the controller acknowledges with a one-cycle pulse.
`timescale 1ns/10ps

module apd_refresh_timer (
  input wire logic i_clk,                     // 50 MHz clock
  input wire logic i_rst_b,                   // Synchronous reset, low
  input wire logic i_ack,                     // Refresh performed, pulse
  output logic o_due                          // Refresh owed, level
);
  import apd_pkg::*;

  logic [9:0] cnt_r;
  logic tick;

  assign tick = (cnt_r == REFI_LAST);

  // ************************************************************
  // Interval counter
  // ************************************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cnt_r <= 10'h000;
    end else if (tick) begin
      cnt_r <= 10'h000;
    end else begin
      cnt_r <= cnt_r + 10'h001;
    end
  end

  // Due flag; a new slot in the ack cycle wins so no refresh is lost
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_due <= 1'b0;
    end else if (tick) begin
      o_due <= 1'b1;
    end else if (i_ack) begin
      o_due <= 1'b0;
    end
  end

endmodule // apd_refresh_timer

// >>> testbench/apd_ctrl_properties.sv
// Concurrent checks on the DRAM strobe controller, bound to its top module.
// Assumes one clock domain and sees only the controller's own ports.
`timescale 1ns/10ps
module apd_ctrl_checker (
  input wire logic i_clk, // 50 MHz clock
  input wire logic i_rst_b, // Synchronous reset, low
  input wire logic o_rd_valid, // Read data pulse
  input wire logic [15:0] o_rd_data, // Read data
  input wire logic o_self_active, // Self-refresh held
  input apd_pkg::apd_pins_t o_pins, // Memory pins
  input wire logic [15:0] o_dq_oe // Data drive enable
);
  import apd_pkg::*;
  // Traffic may hold off a due refresh for a while, so allow some slack
  localparam int REF_SLACK = 200;
  logic ras_n, lo_n, hi_n, we_n, cas_n;
  logic [3:0] rc_cnt_r, pc_cnt_r;
  logic [10:0] ref_cnt_r;
  assign ras_n = o_pins.row_strobe_n;
  assign lo_n = o_pins.low_lane_column_strobe_n;
  assign hi_n = o_pins.high_lane_column_strobe_n;
  assign we_n = o_pins.write_en_n;
  assign cas_n = lo_n & hi_n;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // ************************************************************
  // Spacing counters, saturating so a quiet bus never wraps
  // ************************************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) rc_cnt_r <= 4'hf;
    else if ($fell(ras_n) && cas_n) rc_cnt_r <= 4'h1;
    else if (rc_cnt_r != 4'hf) rc_cnt_r <= rc_cnt_r + 4'h1;
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) pc_cnt_r <= 4'hf;
    else if ($fell(cas_n)) pc_cnt_r <= 4'h1;
    else if (pc_cnt_r != 4'hf) pc_cnt_r <= pc_cnt_r + 4'h1;
  end
  // Self-refresh keeps the memory alive, so it restarts the count
  always_ff @(posedge i_clk) begin
    if (!i_rst_b || o_self_active || ($fell(ras_n) && !cas_n)) ref_cnt_r <= 11'h000;
    else if (ref_cnt_r != 11'h7ff) ref_cnt_r <= ref_cnt_r + 11'h001;
  end
  // ************************************************************
  // Assertions
  // ************************************************************
  AST_ROW_ADDR: assert property (
    $fell(ras_n) && cas_n |-> $stable(o_pins.muxed_address_lines))
    else $error("Address moved at row strobe fall");
  AST_COL_ADDR: assert property (
    $fell(cas_n) && !ras_n |-> $stable(o_pins.muxed_address_lines))
    else $error("Address moved at column strobe fall");
  AST_LANES_RISE: assert property (
    $rose(lo_n) || $rose(hi_n) |-> cas_n)
    else $error("Lane strobes released apart");
  AST_CBR_ORDER: assert property (
    $fell(ras_n) && !cas_n |-> !$past(cas_n))
    else $error("Lane strobe not low before row strobe");
  AST_WRITE_LANES: assert property (
    !we_n && (lo_n != hi_n) |-> o_dq_oe == {{8{!hi_n}}, {8{!lo_n}}})
    else $error("Byte write drives wrong lane");
  AST_READ_UNDRIVEN: assert property (
    we_n |-> o_dq_oe == 16'h0000)
    else $error("Data driven outside a write");
  AST_EARLY_WRITE: assert property (
    $fell(cas_n) && !we_n |-> !$past(we_n))
    else $error("Write enable late for strobe");
  AST_RD_LANES: assert property (
    o_rd_valid |-> !$past(o_pins.out_en_n) && (o_rd_data[7:0] == 8'h00 || !$past(lo_n))
      && (o_rd_data[15:8] == 8'h00 || !$past(hi_n)))
    else $error("Read data lanes wrong");
  AST_PAGE_GAP: assert property (
    $fell(cas_n) |-> pc_cnt_r >= T_PC_CYC)
    else $error("Column cycles too close");
  AST_CYCLE_GAP: assert property (
    $fell(ras_n) && cas_n |-> rc_cnt_r >= T_RC_CYC)
    else $error("Random cycles too close");
  AST_REFRESH_DUE: assert property (
    ref_cnt_r < REFI_CYC + REF_SLACK)
    else $error("Refresh overdue");
endmodule // apd_ctrl_checker

bind apd_ctrl apd_ctrl_checker u_apd_ctrl_checker (.i_clk(i_clk), .i_rst_b(i_rst_b),
  .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_self_active(o_self_active),
  .o_pins(o_pins), .o_dq_oe(o_dq_oe));

// >>> testbench/apd_dram_model.sv
// Behavioural page-mode DRAM with two byte-lane column strobes.
// Assumes the bench resolves the data pins from the controller's enable alone.
`timescale 1ns/10ps
module apd_dram_model (
  input apd_pkg::apd_pins_t i_pins, // Strobes and address
  input wire logic [15:0] i_dq, // Resolved data pins
  output logic [15:0] o_dq, // Value put on the pins
  output logic [15:0] o_dq_oe // High drives, per bit
);
  import apd_pkg::*;
  // ************************************************************
  // Storage and strobe decode
  // ************************************************************
  // Cells never decay, so any refresh kind keeps data
  logic [15:0] mem [logic [19:0]];
  logic [9:0] row_r = 10'h000;
  logic [15:0] out_r = 16'h0000;
  logic acc_r = 1'b0;
  logic ref_r = 1'b0;
  logic cas_n, lo_drv, hi_drv;
  // First lane down opens the merged strobe, last lane up closes it
  assign cas_n = i_pins.low_lane_column_strobe_n & i_pins.high_lane_column_strobe_n;
  // Lanes low at row fall: counter refresh, pins ignored, unless hidden after access
  always @(negedge i_pins.row_strobe_n) begin
    ref_r = !cas_n && !acc_r;
    if (cas_n) row_r = i_pins.muxed_address_lines;
  end
  // Column fall takes the column; a write stores only the strobed lanes
  always @(negedge cas_n) begin
    logic [15:0] w;
    logic [19:0] key;
    if (!i_pins.row_strobe_n) begin
      acc_r = 1'b1;
      key = {row_r, i_pins.muxed_address_lines};
      w = mem.exists(key) ? mem[key] : 16'h0000;
      if (!i_pins.write_en_n) begin
        if (!i_pins.low_lane_column_strobe_n) w[7:0] = i_dq[7:0];
        if (!i_pins.high_lane_column_strobe_n) w[15:8] = i_dq[15:8];
        mem[key] = w;
      end
      out_r = w;
    end
  end
  always @(posedge cas_n) acc_r = 1'b0;
  // Each lane drives only under its own strobe, and never during a write
  assign lo_drv = !i_pins.low_lane_column_strobe_n && !i_pins.out_en_n
    && i_pins.write_en_n && !ref_r;
  assign hi_drv = !i_pins.high_lane_column_strobe_n && !i_pins.out_en_n
    && i_pins.write_en_n && !ref_r;
  assign o_dq_oe = {{8{hi_drv}}, {8{lo_drv}}};
  // Released lanes show the inverse of the held word, so stale data never passes
  assign o_dq = (o_dq_oe & out_r) | (~o_dq_oe & ~out_r);
endmodule // apd_dram_model

// >>> testbench/tb_top.sv
// Self-checking bench for the DRAM strobe controller and a behavioural memory.
// Assumes the checker is bound in; inputs change on the falling clock edge.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin mismatches++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module tb_top;
  import apd_pkg::*;
  // ************************************************************
  // Clock, wiring and bookkeeping
  // ************************************************************
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_req_valid = 1'b0;
  apd_req_t i_req = '0;
  logic i_self_refresh = 1'b0;
  logic o_req_ready, o_rd_valid, o_self_active;
  logic [15:0] o_rd_data, o_dq, o_dq_oe, mdl_dq, mdl_oe;
  apd_pins_t pins_w;
  // Pin level: whoever enables drives; the model shows the inverse of its held word otherwise
  wire logic [15:0] dq_w = (o_dq_oe & o_dq) | (~o_dq_oe & mdl_dq);
  integer seed = 56676;
  integer mismatches = 0;
  integer total_checks = 0;
  logic [15:0] shadow [logic [19:0]];
  always #10 i_clk = ~i_clk;
  apd_ctrl u_apd_ctrl (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_req_valid(i_req_valid),
    .i_req(i_req), .o_req_ready(o_req_ready), .o_rd_valid(o_rd_valid),
    .o_rd_data(o_rd_data), .i_self_refresh(i_self_refresh), .o_self_active(o_self_active),
    .o_pins(pins_w), .i_dq(dq_w), .o_dq(o_dq), .o_dq_oe(o_dq_oe));
  apd_dram_model u_apd_dram_model (.i_pins(pins_w), .i_dq(dq_w), .o_dq(mdl_dq),
    .o_dq_oe(mdl_oe));
  // Both sides driving one pin would be a clash
  always @(negedge i_clk) if (i_rst_b) `CHK("dq_clash", 16'h0000, o_dq_oe & mdl_oe)
  // ************************************************************
  // Expectations and drivers
  // ************************************************************
  function automatic logic [15:0] f_exp(input logic [19:0] key, input logic [1:0] ln);
    logic [15:0] w;
    w = shadow.exists(key) ? shadow[key] : 16'h0000;
    return w & {{8{ln[1]}}, {8{ln[0]}}};
  endfunction
  function automatic void f_wr(input logic [19:0] key, input logic [1:0] ln,
                               input logic [15:0] d);
    logic [15:0] m;
    m = {{8{ln[1]}}, {8{ln[0]}}};
    shadow[key] = (f_exp(key, 2'b11) & ~m) | (d & m);
  endfunction
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // A wait that ran out ends the run
  task automatic tmo(input logic ok);
    if (!ok) begin
      mismatches++;
      $display("ERROR wait expected 1 seen 0");
      final_report();
    end
  endtask
  // One request held until taken; a read then waits for its data pulse
  task automatic access(input logic wr, input logic [1:0] ln, input logic [9:0] row,
                        input logic [9:0] col, input logic [15:0] wd, input logic hold);
    integer n;
    @(negedge i_clk);
    i_req_valid = 1'b1;
    i_req = '{wr, ln, row, col, wd, hold};
    for (n = 0; n < 60 && o_req_ready !== 1'b1; n++) @(negedge i_clk);
    tmo(o_req_ready === 1'b1);
    @(negedge i_clk);
    i_req_valid = 1'b0;
    if (wr) f_wr({row, col}, ln, wd);
    else begin
      for (n = 0; n < 20 && o_rd_valid !== 1'b1; n++) @(negedge i_clk);
      tmo(o_rd_valid === 1'b1);
      `CHK("rd_data", f_exp({row, col}, ln), o_rd_data)
    end
  endtask
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    integer i, r;
    logic [1:0] ln;
    repeat (2) @(negedge i_clk);
    `CHK("rst_pins", PINS_IDLE, pins_w)
    i_rst_b = 1'b1;
    // Corner: top address, word then each lane alone
    access(1'b1, 2'b11, 10'h3ff, 10'h3ff, 16'hffff, 1'b0);
    access(1'b1, 2'b01, 10'h3ff, 10'h3ff, 16'h1234, 1'b0);
    access(1'b0, 2'b10, 10'h3ff, 10'h3ff, 16'h0000, 1'b0);
    access(1'b0, 2'b11, 10'h3ff, 10'h3ff, 16'h0000, 1'b0);
    // Random accesses on a small set so that reads hit earlier writes
    for (i = 0; i < 60; i++) begin
      r = $random(seed);
      ln = (r[1:0] == 2'b00) ? 2'b11 : r[1:0];
      access(r[2], ln, {8'h00, r[4:3]}, {7'h00, r[7:5]}, r[31:16], 1'b0);
    end
    // Page burst up to the last column: writes, then reads, row closed at the end
    for (i = 0; i < 16; i++) begin
      r = $random(seed);
      access(i < 8, 2'b11, 10'h005, 10'h3f8 + 10'(i % 8), r[15:0], i != 15);
    end
    repeat (2000) @(negedge i_clk);
    // Self-refresh: row strobe held, then data must have survived
    i_self_refresh = 1'b1;
    for (i = 0; i < 40 && o_self_active !== 1'b1; i++) @(negedge i_clk);
    tmo(o_self_active === 1'b1);
    repeat (100) @(negedge i_clk);
    `CHK("self_row", 1'b0, pins_w.row_strobe_n)
    i_self_refresh = 1'b0;
    for (i = 0; i < 40 && o_self_active !== 1'b0; i++) @(negedge i_clk);
    tmo(o_self_active === 1'b0);
    access(1'b0, 2'b11, 10'h3ff, 10'h3ff, 16'h0000, 1'b0);
    // Read stream across refresh slots: most slots land mid-read and run hidden
    for (i = 0; i < 200; i++) begin
      r = $random(seed);
      ln = (r[1:0] == 2'b00) ? 2'b11 : r[1:0];
      access(1'b0, ln, {8'h00, r[4:3]}, {7'h00, r[7:5]}, 16'h0000, 1'b0);
    end
    final_report();
  end
endmodule // tb_top
